// ---- src/pir_params.svh ----
// Constants for the interrupt router: IRQ numbers, line indices,
// slot and pin counts and default steering for legacy mode.
// Assumes the router package and main module include this file.
// Function
// - Exactly eight routed request lines; every PCI source drives one.
// - Legacy mode delivers requests only on IRQ 0 to 15.
// - Advanced mode supports 24 controller inputs, 0 to 23.
// - IRQ 16 to 23 exist only in advanced mode, lines A to H.
// - Legacy steering puts each line on one of eleven allowed IRQs.
// - Several lines may be steered to one IRQ and merged.
// - Sources wired together share one routed line.
// - Slot 1 and slot 2 pins wired to lines E to H as tabled.
// - Slot 3 pins go to lines C, D, B, A.
// - Slot 4 pins go to lines D, C, F, G only.
// - Onboard serial-bus controller INTA drives line B.
// - IRQ 0, 1, 2, 8, 13 and NMI keep fixed system sources.
// - First serial port defaults IRQ 4, parallel port IRQ 7; movable.
// - USB, serial ATA and PCIe requests are steered dynamically.
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

`define PIR_NUM_LINES      8
`define PIR_NUM_SLOTS      4
`define PIR_NUM_PINS       4
`define PIR_NUM_IRQ        24
`define PIR_LEGACY_IRQS    16
`define PIR_ADV_BASE_IRQ   16
`define PIR_NUM_DYN        8

// Fixed system IRQ numbers and movable port defaults
`define PIR_IRQ_TIMER      5'h00
`define PIR_IRQ_KEYBOARD   5'h01
`define PIR_IRQ_CASCADE    5'h02
`define PIR_IRQ_RTC        5'h08
`define PIR_IRQ_FPU        5'h0d
`define PIR_IRQ_DISKETTE   5'h06
`define PIR_IRQ_SERIAL_DEF 5'h04
`define PIR_IRQ_PAR_DEF    5'h07
`define PIR_IRQ_PAR2_DEF   5'h05
`define PIR_IRQ_MOUSE      5'h0c
`define PIR_IRQ_IDE        5'h0e
`define PIR_IRQ_SATA       5'h0f

// Allowed legacy steering targets as a 16-bit mask: 3-7, 9-12, 14, 15
`define PIR_LEGACY_ALLOWED 16'hdef8

// Routed line indices A..H
`define PIR_LINE_A 3'h0
`define PIR_LINE_B 3'h1
`define PIR_LINE_C 3'h2
`define PIR_LINE_D 3'h3
`define PIR_LINE_E 3'h4
`define PIR_LINE_F 3'h5
`define PIR_LINE_G 3'h6
`define PIR_LINE_H 3'h7

// Reset steering for each routed line in legacy mode
`define PIR_STEER_DEF 5'h0b

`endif

// ---- src/pir_pkg.sv ----
// Types for the interrupt router.
// Assumes pir_params.svh is on the include path.
`include "pir_params.svh"
package pir_pkg;

    // Controller mode
    typedef enum logic [0:0] {
        PIR_MODE_LEGACY   = 1'b0,
        PIR_MODE_ADVANCED = 1'b1
    } pir_mode_t;

    // Four active-low PCI interrupt pins of one source
    typedef struct packed {
        logic intd_n;
        logic intc_n;
        logic intb_n;
        logic inta_n;
    } pir_pins_t;

    // Steering table write request
    typedef struct packed {
        logic       valid;
        logic [2:0] line;
        logic [4:0] irq;
    } pir_steer_wr_t;

    // Dynamic source assignment request
    typedef struct packed {
        logic       valid;
        logic [2:0] src;
        logic [4:0] irq;
    } pir_dyn_wr_t;

    // Fixed-function interrupt requests, active high
    typedef struct packed {
        logic timer;
        logic keyboard;
        logic cascade;
        logic rtc;
        logic fpu;
        logic diskette;
        logic mouse;
        logic ide;
        logic sata;
        logic serial;
        logic parallel;
        logic parallel2;
    } pir_fixed_t;

endpackage : pir_pkg

// ---- src/pir_steer_table.sv ----
// Steering table: one IRQ number per entry, written one entry a cycle.
// Assumes single clock, async active-low reset; read data registered.
`timescale 1ns/1ns
`default_nettype none
`include "pir_params.svh"
module pir_steer_table #(
    parameter int unsigned ENTRIES = 8,
    parameter logic [4:0]  RST_VAL = 5'h00
) (
    // Clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    // Write port
    input  wire logic                      wr_en_i,
    input  wire logic [$clog2(ENTRIES)-1:0] wr_idx_i,
    input  wire logic [4:0]                wr_irq_i,
    // Registered contents
    output logic [ENTRIES-1:0][4:0]        table_o
);

    logic [ENTRIES-1:0][4:0] mem_r;
    logic [ENTRIES-1:0][4:0] mem_nxt;

    // Next contents: one entry updated per write
    always_comb begin
        mem_nxt = mem_r;
        if (wr_en_i) begin
            mem_nxt[wr_idx_i] = wr_irq_i;
        end
    end

    // Registered storage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mem_r <= {ENTRIES{RST_VAL}};
        end else begin
            mem_r <= mem_nxt;
        end
    end

    assign table_o = mem_r;

endmodule : pir_steer_table
`default_nettype wire

// ---- src/pir_router.sv ----
// Interrupt router: folds PCI pins onto eight routed lines, then
// delivers them as legacy IRQs 0-15 or advanced IRQs 16-23.
// Assumes all inputs synchronous to clk_i; steering written by firmware
// through the plain write ports below.
`timescale 1ns/1ns
`default_nettype none
`include "pir_params.svh"
module pir_router (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    // Mode select
    input  wire logic                 advanced_controller_mode_i,
    // PCI interrupt sources, active low
    input  wire pir_pkg::pir_pins_t   slot_pins_n_i [`PIR_NUM_SLOTS],
    input  wire logic                 serial_bus_inta_n_i,
    // Dynamic sources (USB, serial ATA, PCIe), active high
    input  wire logic [`PIR_NUM_DYN-1:0] dyn_req_i,
    // Fixed-function requests, active high
    input  wire pir_pkg::pir_fixed_t  fixed_req_i,
    input  wire logic                 io_check_i,
    // Steering writes
    input  wire pir_pkg::pir_steer_wr_t steer_wr_i,
    input  wire pir_pkg::pir_dyn_wr_t   dyn_wr_i,
    input  wire logic [4:0]           serial_irq_i,
    input  wire logic [4:0]           parallel_irq_i,
    // Routed lines, active high, and status
    output logic [`PIR_NUM_LINES-1:0] routed_request_line_o,
    output logic                      steer_wr_err_o,
    // Controller inputs
    output logic [`PIR_NUM_IRQ-1:0]   irq_o,
    output logic                      nmi_o
);

    // Is an IRQ a permitted legacy steering target
    function automatic logic legacy_ok(input logic [4:0] irq);
        logic [15:0] allowed;
        allowed = `PIR_LEGACY_ALLOWED;
        legacy_ok = (irq < 5'(`PIR_LEGACY_IRQS)) && allowed[irq[3:0]];
    endfunction : legacy_ok

    // Decode an IRQ number to a one-hot vector over all controller inputs
    function automatic logic [`PIR_NUM_IRQ-1:0] irq_hot(input logic [4:0] irq);
        irq_hot = '0;
        if (irq < 5'(`PIR_NUM_IRQ)) begin
            irq_hot[irq] = 1'b1;
        end
    endfunction : irq_hot

    logic [`PIR_NUM_LINES-1:0]        line_nxt;
    logic [`PIR_NUM_LINES-1:0]        line_r;
    logic [`PIR_NUM_LINES-1:0][4:0]   steer;
    logic [`PIR_NUM_DYN-1:0][4:0]     dyn_map;
    logic [`PIR_NUM_IRQ-1:0]          irq_nxt;
    logic [`PIR_NUM_IRQ-1:0]          irq_r;
    logic                             nmi_r;
    logic                             err_nxt;
    logic                             err_r;
    logic                             steer_ok;
    logic                             dyn_ok;
    logic [`PIR_NUM_SLOTS-1:0][3:0]   slot_req;

    // Convert active-low pins to active-high requests
    generate
        for (genvar s = 0; s < `PIR_NUM_SLOTS; s++) begin : g_slot
            assign slot_req[s] = ~slot_pins_n_i[s];
        end
    endgenerate

    // Board wiring: wire-OR of every pin tied to each routed line
    always_comb begin
        line_nxt = '0;
        // Serial-bus controller on line B
        line_nxt[`PIR_LINE_B] |= ~serial_bus_inta_n_i;
        // Slot 1: A->F, B->G, C->H, D->E
        line_nxt[`PIR_LINE_F] |= slot_req[0][0];
        line_nxt[`PIR_LINE_G] |= slot_req[0][1];
        line_nxt[`PIR_LINE_H] |= slot_req[0][2];
        line_nxt[`PIR_LINE_E] |= slot_req[0][3];
        // Slot 2: A->G, B->F, C->E, D->H
        line_nxt[`PIR_LINE_G] |= slot_req[1][0];
        line_nxt[`PIR_LINE_F] |= slot_req[1][1];
        line_nxt[`PIR_LINE_E] |= slot_req[1][2];
        line_nxt[`PIR_LINE_H] |= slot_req[1][3];
        // Slot 3 follows the table, not the prose example
        line_nxt[`PIR_LINE_C] |= slot_req[2][0];
        line_nxt[`PIR_LINE_D] |= slot_req[2][1];
        line_nxt[`PIR_LINE_B] |= slot_req[2][2];
        line_nxt[`PIR_LINE_A] |= slot_req[2][3];
        // Slot 4 never touches A, B, E or H
        line_nxt[`PIR_LINE_D] |= slot_req[3][0];
        line_nxt[`PIR_LINE_C] |= slot_req[3][1];
        line_nxt[`PIR_LINE_F] |= slot_req[3][2];
        line_nxt[`PIR_LINE_G] |= slot_req[3][3];
    end

    // Line levels registered once; shared sources hold the line up
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            line_r <= '0;
        end else begin
            line_r <= line_nxt;
        end
    end

    // Only allowed legacy targets reach the line steering table
    assign steer_ok = steer_wr_i.valid && legacy_ok(steer_wr_i.irq);
    // Dynamic sources may use any input in advanced mode, only an allowed legacy target in legacy mode
    assign dyn_ok = dyn_wr_i.valid &&
        (advanced_controller_mode_i ?
         (dyn_wr_i.irq < 5'(`PIR_NUM_IRQ)) : legacy_ok(dyn_wr_i.irq));

    // Per-line legacy steering
    pir_steer_table #(
        .ENTRIES (`PIR_NUM_LINES),
        .RST_VAL (`PIR_STEER_DEF)
    ) u_line_steer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .wr_en_i   (steer_ok),
        .wr_idx_i  (steer_wr_i.line),
        .wr_irq_i  (steer_wr_i.irq),
        .table_o   (steer)
    );

    // Assignment of dynamically routed functions
    pir_steer_table #(
        .ENTRIES (`PIR_NUM_DYN),
        .RST_VAL (`PIR_STEER_DEF)
    ) u_dyn_steer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .wr_en_i   (dyn_ok),
        .wr_idx_i  (dyn_wr_i.src),
        .wr_irq_i  (dyn_wr_i.irq),
        .table_o   (dyn_map)
    );

    // Rejected steering writes are flagged for one cycle
    always_comb begin
        err_nxt = (steer_wr_i.valid && !steer_ok) ||
                  (dyn_wr_i.valid && !dyn_ok);
    end

    // Delivery to controller inputs
    always_comb begin
        irq_nxt = '0;
        // Fixed system sources
        if (fixed_req_i.timer)     irq_nxt |= irq_hot(`PIR_IRQ_TIMER);
        if (fixed_req_i.keyboard)  irq_nxt |= irq_hot(`PIR_IRQ_KEYBOARD);
        if (fixed_req_i.cascade)   irq_nxt |= irq_hot(`PIR_IRQ_CASCADE);
        if (fixed_req_i.rtc)       irq_nxt |= irq_hot(`PIR_IRQ_RTC);
        if (fixed_req_i.fpu)       irq_nxt |= irq_hot(`PIR_IRQ_FPU);
        if (fixed_req_i.diskette)  irq_nxt |= irq_hot(`PIR_IRQ_DISKETTE);
        if (fixed_req_i.mouse)     irq_nxt |= irq_hot(`PIR_IRQ_MOUSE);
        if (fixed_req_i.ide)       irq_nxt |= irq_hot(`PIR_IRQ_IDE);
        if (fixed_req_i.sata)      irq_nxt |= irq_hot(`PIR_IRQ_SATA);
        if (fixed_req_i.parallel2) irq_nxt |= irq_hot(`PIR_IRQ_PAR2_DEF);
        // Movable ports; an IRQ outside 0-15 leaves the port silent
        if (fixed_req_i.serial && serial_irq_i < 5'(`PIR_LEGACY_IRQS)) begin
            irq_nxt |= irq_hot(serial_irq_i);
        end
        if (fixed_req_i.parallel && parallel_irq_i < 5'(`PIR_LEGACY_IRQS)) begin
            irq_nxt |= irq_hot(parallel_irq_i);
        end
        // Dynamic functions
        for (int d = 0; d < `PIR_NUM_DYN; d++) begin
            if (dyn_req_i[d]) irq_nxt |= irq_hot(dyn_map[d]);
        end
        // Routed lines
        for (int l = 0; l < `PIR_NUM_LINES; l++) begin
            if (line_r[l]) begin
                if (advanced_controller_mode_i) begin
                    irq_nxt[`PIR_ADV_BASE_IRQ + l] = 1'b1;
                end else begin
                    irq_nxt |= irq_hot(steer[l]);
                end
            end
        end
        // Upper inputs silent outside advanced mode
        if (!advanced_controller_mode_i) begin
            irq_nxt[`PIR_NUM_IRQ-1:`PIR_LEGACY_IRQS] = '0;
        end
    end

    // Controller-facing outputs from flip-flops
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_r <= '0;
            nmi_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            nmi_r <= io_check_i;
            err_r <= err_nxt;
        end
    end

    assign routed_request_line_o = line_r;
    assign irq_o                 = irq_r;
    assign nmi_o                 = nmi_r;
    assign steer_wr_err_o        = err_r;

endmodule : pir_router
`default_nettype wire

// ---- test/pir_router_chk.sv ----
// Port-level checker for the interrupt router, bound to its top module.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "pir_params.svh"
module pir_router_chk (
    // Clock, reset and mode
    input wire logic                      clk_i,
    input wire logic                      reset_n_i,
    input wire logic                      advanced_controller_mode_i,
    // Requests and writes
    input wire pir_pkg::pir_pins_t        slot_pins_n_i [`PIR_NUM_SLOTS],
    input wire logic                      serial_bus_inta_n_i,
    input wire logic [`PIR_NUM_DYN-1:0]   dyn_req_i,
    input wire pir_pkg::pir_fixed_t       fixed_req_i,
    input wire logic                      io_check_i,
    input wire pir_pkg::pir_steer_wr_t    steer_wr_i,
    input wire pir_pkg::pir_dyn_wr_t      dyn_wr_i,
    // Outputs watched
    input wire logic [`PIR_NUM_LINES-1:0] routed_request_line_o,
    input wire logic                      steer_wr_err_o,
    input wire logic [`PIR_NUM_IRQ-1:0]   irq_o,
    input wire logic                      nmi_o
);
    logic [7:0] exp_line;
    logic [4:0] fix_v;
    logic       bad_wr;

    // Eleven steerable IRQs: 3-7, 9-12, 14, 15
    function automatic logic ok(input logic [4:0] q);
        return !q[4] && q[3:0] inside {3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    endfunction : ok

    // Wire-OR of the active-low pins onto each line, bit 0 is line A
    always_comb begin
        exp_line[0] = ~slot_pins_n_i[2].intd_n;
        exp_line[1] = ~slot_pins_n_i[2].intc_n | ~serial_bus_inta_n_i;
        exp_line[2] = ~slot_pins_n_i[2].inta_n | ~slot_pins_n_i[3].intb_n;
        exp_line[3] = ~slot_pins_n_i[2].intb_n | ~slot_pins_n_i[3].inta_n;
        exp_line[4] = ~slot_pins_n_i[0].intd_n | ~slot_pins_n_i[1].intc_n;
        exp_line[5] = ~slot_pins_n_i[0].inta_n | ~slot_pins_n_i[1].intb_n
                    | ~slot_pins_n_i[3].intc_n;
        exp_line[6] = ~slot_pins_n_i[0].intb_n | ~slot_pins_n_i[1].inta_n
                    | ~slot_pins_n_i[3].intd_n;
        exp_line[7] = ~slot_pins_n_i[0].intc_n | ~slot_pins_n_i[1].intd_n;
    end

    // Reserved sources, and writes that must be refused
    assign fix_v = {fixed_req_i.fpu, fixed_req_i.rtc, fixed_req_i.cascade,
                    fixed_req_i.keyboard, fixed_req_i.timer};
    assign bad_wr = (steer_wr_i.valid && !ok(steer_wr_i.irq))
                 || (dyn_wr_i.valid && (advanced_controller_mode_i ?
                     dyn_wr_i.irq > 5'h17 : !ok(dyn_wr_i.irq)));

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    legacy_hi_a: assert property (
        !$past(advanced_controller_mode_i) |-> irq_o[23:16] == 8'h00)
        else $error("IRQ 16-23 active in legacy mode");
    adv_line_a: assert property (
        $past(advanced_controller_mode_i) && $past(dyn_req_i) == '0
        |-> irq_o[23:16] == $past(routed_request_line_o))
        else $error("advanced IRQ does not follow its line");
    adv_cover_a: assert property (
        $past(advanced_controller_mode_i)
        |-> (irq_o[23:16] & $past(routed_request_line_o))
            == $past(routed_request_line_o))
        else $error("active line missing on its advanced IRQ");
    slot_map_a: assert property (
        $past(reset_n_i) |-> routed_request_line_o == $past(exp_line))
        else $error("routed lines differ from pin wiring");
    serial_bus_a: assert property (
        !serial_bus_inta_n_i |=> routed_request_line_o[1])
        else $error("serial-bus request missing on line B");
    nmi_a: assert property (
        $past(reset_n_i) |-> nmi_o == $past(io_check_i))
        else $error("NMI does not follow channel check");
    fixed_irq_a: assert property (
        $past(reset_n_i) |-> ({irq_o[13], irq_o[8], irq_o[2:0]}
        & $past(fix_v)) == $past(fix_v))
        else $error("reserved IRQ missing");
    wr_err_a: assert property (
        1'b1 |=> steer_wr_err_o == $past(bad_wr))
        else $error("write error flag wrong");
    steer_take_a: assert property (
        steer_wr_i.valid && ok(steer_wr_i.irq) ##1 !steer_wr_i.valid ##1
        (!advanced_controller_mode_i
         && routed_request_line_o[$past(steer_wr_i.line, 2)])
        |=> irq_o[$past(steer_wr_i.irq, 3)])
        else $error("steered line missing on its IRQ");
endmodule : pir_router_chk

bind pir_router pir_router_chk pir_router_chk_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .advanced_controller_mode_i(advanced_controller_mode_i),
    .slot_pins_n_i(slot_pins_n_i), .serial_bus_inta_n_i(serial_bus_inta_n_i),
    .dyn_req_i(dyn_req_i),
    .fixed_req_i(fixed_req_i), .io_check_i(io_check_i),
    .steer_wr_i(steer_wr_i), .dyn_wr_i(dyn_wr_i),
    .routed_request_line_o(routed_request_line_o),
    .steer_wr_err_o(steer_wr_err_o), .irq_o(irq_o), .nmi_o(nmi_o));
`default_nettype wire

// ---- test/pir_src_model.sv ----
// Model of the PCI sources: four add-in cards and the onboard controller.
// Assumes requests come as active-high levels from the bench.
`timescale 1ns/1ns
`default_nettype none
module pir_src_model (
    // Card requests, bit k is the card's k-th interrupt
    input  wire logic [3:0]        card_req_i [4],
    input  wire logic              bus_req_i,
    // Pins, active low
    output var pir_pkg::pir_pins_t slot_pins_n_o [4],
    output var logic               serial_bus_inta_n_o
);
    // Pins are levels held while a request stands; first interrupt on INTA
    always_comb begin
        for (int s = 0; s < 4; s++) begin
            slot_pins_n_o[s] = ~card_req_i[s];
        end
        serial_bus_inta_n_o = ~bus_req_i;
    end
endmodule : pir_src_model
`default_nettype wire

// ---- test/pir_router_tb.sv ----
// Self-checking bench for the interrupt router.
// Assumes the checker is bound and the source model drives the pins.
`timescale 1ns/1ns
`default_nettype none
module pir_router_tb;
    // Routed line of each slot pin, INTA first
    localparam int WIRE [4][4] = '{'{5, 6, 7, 4}, '{6, 5, 4, 7},
                                   '{2, 3, 1, 0}, '{3, 2, 5, 6}};
    logic                   clk_i, reset_n_i, mode, bus_req, io_chk;
    logic                   bus_n, err, nmi;
    logic [3:0]             card_req [4];
    pir_pkg::pir_pins_t     pins_n [4];
    logic [7:0]             dyn_req, routed;
    logic [4:0]             ser_irq, par_irq;
    logic [23:0]            irq;
    pir_pkg::pir_fixed_t    fixed_req;
    pir_pkg::pir_steer_wr_t steer_wr;
    pir_pkg::pir_dyn_wr_t   dyn_wr;
    int                     n_errors, n_checks;

    pir_src_model pir_src_model_inst (.card_req_i(card_req),
        .bus_req_i(bus_req), .slot_pins_n_o(pins_n),
        .serial_bus_inta_n_o(bus_n));
    pir_router pir_router_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .advanced_controller_mode_i(mode), .slot_pins_n_i(pins_n),
        .serial_bus_inta_n_i(bus_n), .dyn_req_i(dyn_req),
        .fixed_req_i(fixed_req), .io_check_i(io_chk), .steer_wr_i(steer_wr),
        .dyn_wr_i(dyn_wr), .serial_irq_i(ser_irq), .parallel_irq_i(par_irq),
        .routed_request_line_o(routed), .steer_wr_err_o(err), .irq_o(irq),
        .nmi_o(nmi));

    task automatic chk(input string what, input logic [23:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask : tick

    // One write; a gap cycle first so valid never toggles in one step
    task automatic wr(input bit dyn, input logic [2:0] idx,
                      input logic [4:0] q, input logic e);
        tick(1);
        if (dyn) dyn_wr = '{1'b1, idx, q};
        else steer_wr = '{1'b1, idx, q};
        tick(1);
        chk("write error", err, e);
        dyn_wr.valid = 1'b0;
        steer_wr.valid = 1'b0;
    endtask : wr

    task automatic t_wiring();
        mode = 1'b1;
        for (int s = 0; s < 4; s++) for (int p = 0; p < 4; p++) begin
            card_req[s][p] = 1'b1;
            tick(3);
            chk("line", routed, 24'h1 << WIRE[s][p]);
            chk("adv irq", irq, 24'h1 << (16 + WIRE[s][p]));
            card_req[s][p] = 1'b0;
        end
        bus_req = 1'b1;
        card_req[2][2] = 1'b1;
        tick(3);
        card_req[2][2] = 1'b0;
        tick(3);
        chk("shared line", routed, 24'h2);
        bus_req = 1'b0;
        tick(3);
        chk("line idle", routed, 24'h0);
    endtask : t_wiring

    task automatic t_steer();
        int ok_q[$] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
        int bad_q[$] = '{0, 1, 2, 8, 13, 16, 23};
        mode = 1'b0;
        card_req[2][3] = 1'b1;
        tick(3);
        chk("default", irq, 24'h800);
        foreach (ok_q[i]) begin
            wr(0, 3'h0, 5'(ok_q[i]), 1'b0);
            tick(2);
            chk("steer", irq, 24'h1 << ok_q[i]);
        end
        foreach (bad_q[i]) begin
            wr(0, 3'h0, 5'(bad_q[i]), 1'b1);
            tick(2);
            chk("refused", irq, 24'h8000);
        end
        card_req[2][3] = 1'b0;
        card_req[2][0] = 1'b1;
        card_req[2][1] = 1'b1;
        wr(0, 3'h2, 5'h0a, 1'b0);
        wr(0, 3'h3, 5'h0a, 1'b0);
        tick(2);
        chk("merged both", irq, 24'h400);
        card_req[2][0] = 1'b0;
        tick(3);
        chk("merged", irq, 24'h400);
        card_req[2][1] = 1'b0;
    endtask : t_steer

    task automatic t_fixed();
        fixed_req = '{timer: 1, keyboard: 1, cascade: 1, rtc: 1, fpu: 1,
                      default: 0};
        io_chk = 1'b1;
        tick(3);
        chk("reserved", irq, 24'h002107);
        chk("nmi", nmi, 1'b1);
        fixed_req = '{serial: 1, parallel: 1, default: 0};
        io_chk = 1'b0;
        tick(3);
        chk("ports", irq, 24'h90);
        chk("nmi off", nmi, 1'b0);
        ser_irq = 5'h03;
        par_irq = 5'h09;
        tick(3);
        chk("ports moved", irq, 24'h208);
        ser_irq = 5'h10;
        tick(3);
        chk("port off", irq, 24'h200);
        fixed_req = '{diskette: 1, mouse: 1, ide: 1, sata: 1, parallel2: 1,
                      default: 0};
        tick(3);
        chk("other fixed", irq, 24'h00d060);
        fixed_req = '0;
    endtask : t_fixed

    task automatic t_dyn();
        wr(1, 3'h0, 5'h09, 1'b0);
        wr(1, 3'h2, 5'h0d, 1'b1);
        dyn_req = 8'h01;
        tick(3);
        chk("dyn legacy", irq, 24'h200);
        mode = 1'b1;
        wr(1, 3'h0, 5'h14, 1'b0);
        wr(1, 3'h1, 5'h18, 1'b1);
        tick(2);
        chk("dyn adv", irq, 24'h100000);
        dyn_req = 8'h00;
    endtask : t_dyn

    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Stimulus changes at the falling edge, away from sampling
    initial begin
        reset_n_i = 1'b0;
        mode = 1'b0;
        bus_req = 1'b0;
        io_chk = 1'b0;
        card_req = '{default: 4'h0};
        dyn_req = 8'h00;
        ser_irq = 5'h04;
        par_irq = 5'h07;
        fixed_req = '0;
        steer_wr = '0;
        dyn_wr = '0;
        tick(16);
        reset_n_i = 1'b1;
        t_wiring();
        t_steer();
        t_fixed();
        t_dyn();
        conclude();
    end

    // Whole run takes under a thousand cycles
    initial begin
        #40000;
        n_errors++;
        conclude();
    end
endmodule : pir_router_tb
`default_nettype wire
